// ===== design/outer_loop_pkg.sv
// Purpose: constants for the outer trim loop enable sequencer
// Assumes: 100 MHz sys_clk
// Notes: times kept in their own units, cycle counts derived
package outer_loop_pkg;
	localparam int CLK_MHZ = 100;
	localparam int TICK_MS = 20;
	localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
	localparam int QUAL_MS = 10;
	localparam int QUAL_CYCLES = QUAL_MS * 1000 * CLK_MHZ;
	localparam int TRIM_W = 16;
	localparam logic [1:0] FUNC_BRUSH = 2'h1;
	localparam logic [1:0] FUNC_JOG = 2'h2;
	localparam logic [1:0] FUNC_LOOP_EN = 2'h3;
	localparam logic [1:0] FUNC_DEFAULT = 2'h1;
	typedef enum logic [1:0] {
		ORIGIN_KEYPAD = 2'b00,
		ORIGIN_TERMINAL = 2'b01,
		ORIGIN_SERIAL = 2'b10,
		ORIGIN_NETWORK = 2'b11
	} origin_t;
	typedef enum logic [1:0] {
		REG_TYPE1 = 2'b00,
		REG_TYPE2 = 2'b01,
		REG_TYPE3 = 2'b10
	} reg_type_t;
endpackage

// ===== design/outer_loop_enable_sequencer.sv
// Purpose: enable, input qualification and 20 ms scheduling for the outer trim loop
// Assumes: loop arithmetic lives outside; this block gates, resets and routes its result
// Notes: pins pass two flip-flops before use
`timescale 1ns/1ps
module outer_loop_enable_sequencer #(
	parameter int TICK_CYC = outer_loop_pkg::TICK_CYCLES,
	parameter int QUAL_CYC = outer_loop_pkg::QUAL_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic regulator_input_a,
	input wire logic expansion_input_e,
	input wire logic network_enable_cmd,
	input wire logic expansion_fitted,
	input wire logic [1:0] command_origin,
	input wire logic [1:0] input_a_function,
	input wire logic drive_running,
	input wire logic outer_pi_break_nonzero,
	input wire logic [1:0] regulator_type,
	input wire logic signed [outer_loop_pkg::TRIM_W-1:0] loop_calc_result,
	input wire logic signed [outer_loop_pkg::TRIM_W-1:0] speed_reference,
	output logic outer_loop_run_flag,
	output logic input_a_state,
	output logic input_e_state,
	output logic brush_ok,
	output logic jog_speed2_sel,
	output logic loop_exec_pulse,
	output logic loop_stage_reset,
	output logic integral_enable,
	output logic signed [outer_loop_pkg::TRIM_W-1:0] outer_loop_result,
	output logic signed [outer_loop_pkg::TRIM_W-1:0] trimmed_reference,
	output logic signed [outer_loop_pkg::TRIM_W-1:0] current_loop_trim
);
	localparam int TW = outer_loop_pkg::TRIM_W;
	logic [1:0] a_sync_r;
	logic [1:0] e_sync_r;
	logic [31:0] a_cnt_r;
	logic [31:0] e_cnt_r;
	logic [31:0] tick_cnt_r;
	logic tick_w;
	logic sel_flag_w;
	logic allow_w;
	logic run_now_w;
	logic a_on_nxt;
	logic e_on_nxt;
	logic signed [TW-1:0] result_nxt;
	logic net_w;
	logic [31:0] qual_lim;
	logic [31:0] tick_lim;
	logic type3_w;
	logic signed [TW-1:0] ref_sum_w;
	logic signed [TW-1:0] trimmed_nxt;
	logic signed [TW-1:0] current_nxt;

	assign qual_lim = 32'(QUAL_CYC);
	assign tick_lim = 32'(TICK_CYC - 1);
	assign net_w = command_origin == outer_loop_pkg::ORIGIN_NETWORK;
	// a high that has held past the window reports on; any low reports off
	assign a_on_nxt = a_sync_r[1] && (a_cnt_r >= qual_lim);
	assign e_on_nxt = e_sync_r[1] && (e_cnt_r >= qual_lim);
	assign allow_w = expansion_fitted || net_w
		|| (input_a_function == outer_loop_pkg::FUNC_LOOP_EN);
	// source select; input A only counts when set to the enable function
	assign sel_flag_w = net_w ? network_enable_cmd
		: (expansion_fitted ? input_e_state
		: (input_a_state && input_a_function == outer_loop_pkg::FUNC_LOOP_EN));
	assign tick_w = tick_cnt_r == tick_lim;
	assign run_now_w = outer_loop_run_flag && drive_running;
	assign result_nxt = run_now_w ? loop_calc_result : '0;
	// type 3 bypasses the speed path, so the reference passes untouched there
	assign type3_w = regulator_type == outer_loop_pkg::REG_TYPE3;
	assign ref_sum_w = TW'(speed_reference + result_nxt);
	assign trimmed_nxt = type3_w ? speed_reference : ref_sum_w;
	assign current_nxt = type3_w ? result_nxt : '0;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			a_sync_r <= 2'h0;
			e_sync_r <= 2'h0;
		end
		else if (clk_en)
		begin
			a_sync_r <= {a_sync_r[0], regulator_input_a};
			e_sync_r <= {e_sync_r[0], expansion_input_e};
		end
	end

	// counters saturate so a long high never wraps back to off
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			a_cnt_r <= 32'h0;
			e_cnt_r <= 32'h0;
		end
		else if (clk_en)
		begin
			a_cnt_r <= !a_sync_r[1] ? 32'h0 : (a_cnt_r >= qual_lim ? a_cnt_r : a_cnt_r + 32'h1);
			e_cnt_r <= !e_sync_r[1] ? 32'h0 : (e_cnt_r >= qual_lim ? e_cnt_r : e_cnt_r + 32'h1);
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			input_a_state <= 1'b0;
		else if (clk_en)
			input_a_state <= a_on_nxt;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			input_e_state <= 1'b0;
		else if (clk_en)
			input_e_state <= e_on_nxt;
	end

	// off reads as worn, so a missing indicator is never taken as healthy
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			brush_ok <= 1'b0;
		else if (clk_en)
			brush_ok <= a_on_nxt && input_a_function == outer_loop_pkg::FUNC_BRUSH;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			jog_speed2_sel <= 1'b0;
		else if (clk_en)
			jog_speed2_sel <= a_on_nxt && input_a_function == outer_loop_pkg::FUNC_JOG;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			tick_cnt_r <= 32'h0;
		else if (clk_en)
			tick_cnt_r <= tick_w ? 32'h0 : tick_cnt_r + 32'h1;
	end

	// flag only moves on a tick, so enable changes land at the next execution
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			outer_loop_run_flag <= 1'b0;
		else if (clk_en && tick_w)
			outer_loop_run_flag <= allow_w && sel_flag_w;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			loop_exec_pulse <= 1'b0;
		else if (clk_en)
			loop_exec_pulse <= tick_w && run_now_w;
	end

	// reset level high during rst so the stages never start from garbage
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			loop_stage_reset <= 1'b1;
		else if (clk_en)
			loop_stage_reset <= !run_now_w;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			integral_enable <= 1'b0;
		else if (clk_en)
			integral_enable <= run_now_w && outer_pi_break_nonzero;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			outer_loop_result <= '0;
		else if (clk_en)
			outer_loop_result <= result_nxt;
	end

	// the sum wraps on overflow; limiting is left to the reference consumer
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			trimmed_reference <= '0;
		else if (clk_en)
			trimmed_reference <= trimmed_nxt;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			current_loop_trim <= '0;
		else if (clk_en)
			current_loop_trim <= current_nxt;
	end
endmodule

// ===== tb/outer_loop_checker.sv
// Purpose: port checks for the outer loop enable sequencer
// Assumes: bench runs tick 20 and qualify 5 cycles, clk_en high
// Notes: bounds follow those short counts
`timescale 1ns/1ps
module outer_loop_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic regulator_input_a,
	input wire logic drive_running,
	input wire logic outer_pi_break_nonzero,
	input wire logic [1:0] input_a_function,
	input wire logic [1:0] regulator_type,
	input wire logic outer_loop_run_flag,
	input wire logic input_a_state,
	input wire logic brush_ok,
	input wire logic loop_exec_pulse,
	input wire logic loop_stage_reset,
	input wire logic integral_enable,
	input wire logic signed [15:0] outer_loop_result,
	input wire logic signed [15:0] current_loop_trim
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	property p_stop; !drive_running |=> outer_loop_result == 0 && loop_stage_reset; endproperty
	a_stop: assert property (p_stop) else $error("result not held at zero");
	property p_run; loop_exec_pulse |-> $past(outer_loop_run_flag) && $past(drive_running); endproperty
	a_run: assert property (p_run) else $error("loop ran without flag");
	property p_gap; loop_exec_pulse |=> !loop_exec_pulse [*8]; endproperty
	a_gap: assert property (p_gap) else $error("ticks too close");
	property p_qual; $rose(input_a_state) |-> $past(regulator_input_a, 3) && $past(regulator_input_a, 6); endproperty
	a_qual: assert property (p_qual) else $error("input on too early");
	property p_off; $fell(regulator_input_a) |-> ##[1:4] !input_a_state; endproperty
	a_off: assert property (p_off) else $error("input not off");
	property p_brush; brush_ok |-> $past(input_a_function) == 2'h1; endproperty
	a_brush: assert property (p_brush) else $error("brush state wrong function");
	property p_prop; !outer_pi_break_nonzero |=> !integral_enable; endproperty
	a_prop: assert property (p_prop) else $error("integral with zero break");
	property p_cur; $past(regulator_type) != 2'h2 |-> current_loop_trim == 0; endproperty
	a_cur: assert property (p_cur) else $error("current trim outside type 3");
endmodule
bind outer_loop_enable_sequencer outer_loop_checker outer_loop_checker_i (.*);

// ===== tb/drive_model.sv
// Purpose: run sequencer and network master stand-in
// Assumes: levels follow requests one edge later
// Notes: no glitches, a real master may be slower
`timescale 1ns/1ps
module drive_model (
	input wire logic sys_clk,
	input wire logic run_req,
	input wire logic net_req,
	output logic drive_running,
	output logic network_enable_cmd
);
	always_ff @(posedge sys_clk)
	begin
		drive_running <= run_req;
		network_enable_cmd <= net_req;
	end
endmodule

// ===== tb/tb_top.sv
// Purpose: bench for the outer loop enable sequencer
// Assumes: short tick and qualify counts
// Notes: rows first, odd cases by hand
`timescale 1ns/1ps
module tb_top;
	logic sys_clk = 0, rst = 1, clk_en = 1, regulator_input_a = 0, expansion_input_e = 0;
	logic expansion_fitted = 0, outer_pi_break_nonzero = 0, run_req = 1, net_req = 0, x;
	logic [1:0] command_origin = 0, input_a_function = 1, regulator_type = 0;
	logic signed [15:0] loop_calc_result = 16'h0123, speed_reference = 16'h1000;
	logic drive_running, network_enable_cmd, outer_loop_run_flag, input_a_state, input_e_state;
	logic brush_ok, jog_speed2_sel, loop_exec_pulse, loop_stage_reset, integral_enable;
	logic signed [15:0] outer_loop_result, trimmed_reference, current_loop_trim;
	logic [8:0] rows [7] = '{9'h193, 9'h1FC, 9'h0D5, 9'h07A, 9'h139, 9'h09E, 9'h02A};
	int n_mismatch = 0, checks_done = 0, k;
	outer_loop_enable_sequencer #(.TICK_CYC(20), .QUAL_CYC(5)) outer_loop_enable_sequencer_i (.*);
	drive_model drive_model_i (.*);
	initial forever #5 sys_clk = ~sys_clk;
	task step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic got, input logic want);
		checks_done++;
		if (got !== want) begin n_mismatch++; $display("mismatch at %0t: %b not %b", $time, got, want); end
	endtask
	task wp;
		for (k = 0; k < 40 && loop_exec_pulse !== 1'b1; k++) step(1);
		if (k == 40) begin n_mismatch++; end_sim; end
	endtask
	initial
	begin
		step(16);
		chk(loop_stage_reset, 1'b1);
		chk(outer_loop_run_flag, 1'b0);
		rst = 0;
		for (int r = 0; r < 7; r++)
		begin
			{command_origin, expansion_fitted, input_a_function, regulator_input_a,
				expansion_input_e, net_req, x} = rows[r];
			outer_pi_break_nonzero = r[0];
			step(60);
			chk(outer_loop_run_flag, x);
			chk(input_a_state, regulator_input_a);
			chk(input_e_state, expansion_input_e);
			chk(brush_ok, regulator_input_a && input_a_function == 2'h1);
			chk(jog_speed2_sel, regulator_input_a && input_a_function == 2'h2);
			chk(integral_enable, x && r[0]);
			chk(outer_loop_result === (x ? loop_calc_result : 16'h0000), 1'b1);
			chk(trimmed_reference === (x ? 16'h1123 : 16'h1000), 1'b1);
			$display("row %0d done", r);
		end
		regulator_input_a = 1;
		step(3);
		regulator_input_a = 0;
		step(40);
		chk(input_a_state, 1'b0);
		chk(outer_loop_run_flag, 1'b0);
		regulator_input_a = 1;
		input_a_function = 2'h3;
		regulator_type = 2'h2;
		step(60);
		chk(current_loop_trim === loop_calc_result, 1'b1);
		chk(trimmed_reference === speed_reference, 1'b1);
		wp;
		step(1);
		wp;
		chk(k == 19, 1'b1);
		run_req = 0;
		step(3);
		chk(loop_stage_reset, 1'b1);
		chk(outer_loop_result === 16'h0000, 1'b1);
		run_req = 1;
		regulator_input_a = 0;
		step(10);
		chk(outer_loop_run_flag, 1'b1);
		step(15);
		chk(outer_loop_run_flag, 1'b0);
		rst = 1;
		step(2);
		chk(loop_stage_reset, 1'b1);
		chk(outer_loop_result === 16'h0000, 1'b1);
		rst = 0;
		step(2);
		chk(outer_loop_run_flag, 1'b0);
		$display("hand cases done");
		end_sim;
	end
endmodule
